// ---- design/bus_handover_defs.svh ----
// Timing counts, codes and reset values of the bus handover logic
`ifndef BUS_HANDOVER_DEFS_SVH
`define BUS_HANDOVER_DEFS_SVH
`define QS_NOP 2'h0
`define QS_FIRST 2'h1
`define QS_FLUSH 2'h2
`define QS_NEXT 2'h3
`define IDLE_START_NS 30
`define CLK_PERIOD_NS 10
`define IDLE_START_CYC (`IDLE_START_NS / `CLK_PERIOD_NS)
`define LOCK_RST 1'h1
`endif

// ---- design/bus_handover_pkg.sv ----
// Types shared by the bus handover logic
package bus_handover_pkg;
   typedef enum logic [4:0] {
      HO_OWN = 5'h01,
      HO_GRANT = 5'h02,
      HO_HELD = 5'h04,
      HO_RECLAIM = 5'h08,
      HO_IDLE = 5'h10
   } handover_state_t;
   typedef enum logic [2:0] {
      CYC_NONE = 3'h0,
      CYC_ADDR = 3'h1,
      CYC_SECOND = 3'h2,
      CYC_THIRD = 3'h3,
      CYC_FINAL = 3'h4
   } cycle_phase_t;
endpackage

// ---- design/rg_link_if.sv ----
// Carrier between the handover core and one request/grant pin channel
`timescale 1ns/10ps
interface rg_link_if;
   logic pulse_seen;
   logic drive_pulse;
   modport core (input pulse_seen, output drive_pulse);
   modport pin (output pulse_seen, input drive_pulse);
endinterface

// ---- design/rg_pin_channel.sv ----
// One request/grant pin: synchroniser, falling-pulse detect and open-drain drive
`timescale 1ns/10ps
module rg_pin_channel
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_b,
   rg_link_if.pin link
);
   logic sync_a;
   logic sync_b;
   logic prev;
   logic echo_d1;
   logic echo_d2;
   // ----------------------------------------
   // Synchroniser and edge detect
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         sync_a <= 1'h1;
         sync_b <= 1'h1;
         prev <= 1'h1;
         pin_oe_b <= 1'h1;
         pin_out <= 1'h0;
         echo_d1 <= 1'h0;
         echo_d2 <= 1'h0;
      end
      else
      begin
         sync_a <= pin_in;
         sync_b <= sync_a;
         prev <= sync_b;
         // RULE_17 drive own pulse
         pin_oe_b <= ~link.drive_pulse;
         // Pin value is always low; enable decides the level
         pin_out <= 1'h0;
         // Own grant pulse reaches the detector two clocks later
         echo_d1 <= ~pin_oe_b;
         echo_d2 <= echo_d1;
      end
   end
   // RULE_17 sample low pulse, own echo masked
   assign link.pulse_seen = prev & ~sync_b & ~echo_d2;
endmodule // rg_pin_channel

// ---- design/max_mode_bus_handover.sv ----
// Maximum-mode bus handover: request/grant, bus lock and queue status
//
// Behaviour
// RULE_01: Channel A wins over channel B.
// RULE_02: Requester opens with one-clock low pulse.
// RULE_03: Grant pulse in final/addr state, then float.
// RULE_04: Requester's third pulse releases the bus.
// RULE_05: Reclaim next clock, then final or addr.
// RULE_06: Three pulses, then one idle clock.
// RULE_07: Memory-cycle release needs early, unlocked, non-ack.
// RULE_08: Idle bus released during next clock.
// RULE_09: Idle may start cycle within three clocks.
// RULE_10: Lock prefix holds lock through next instruction.
// RULE_11: Ack pair locked, dropped in second ack.
// RULE_12: Queue code shown the clock after.
// RULE_13: Queue status outputs never float.
// RULE_14: Queue codes: nop, first, flush, next.
// RULE_15: Former byte-high enable stays one, floats high.
// RULE_16: Max-mode functions only with strap grounded; lock_prefix still drives bus_lock_b with the strap high.
// RULE_17: Sample on rising edge, drive own pulse only.
// RULE_18: No bus cycles while granted away.
`timescale 1ns/10ps
`include "bus_handover_defs.svh"
module max_mode_bus_handover
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic mode_strap,
   input wire logic req_grant_a_in,
   output logic req_grant_a_out,
   output logic req_grant_a_oe_b,
   input wire logic req_grant_b_in,
   output logic req_grant_b_out,
   output logic req_grant_b_oe_b,
   input wire bus_handover_pkg::cycle_phase_t cycle_phase,
   input wire logic cycle_pending,
   input wire logic int_ack_first,
   input wire logic int_ack_second,
   input wire logic lock_prefix,
   input wire logic instr_done,
   input wire logic [1:0] queue_op,
   output logic bus_float,
   output logic bus_owned,
   output logic bus_lock_b,
   output logic bus_lock_oe_b,
   output logic queue_state_hi,
   output logic queue_state_lo,
   output logic byte_hi_en,
   output logic byte_hi_oe_b
);
   import bus_handover_pkg::*;
   rg_link_if link_a ();
   rg_link_if link_b ();
   handover_state_t state;
   handover_state_t next_state;
   logic [1:0] owner;
   logic req_taken;
   logic late;
   logic ack_in_cycle;
   logic lock_prefix_hold;
   logic lock_ack_hold;
   logic [1:0] idle_cnt;
   logic max_mode;
   logic strap_s1;
   logic strap_s2;
   logic drive_a;
   logic drive_b;
   // ----------------------------------------
   // Pin channels
   // ----------------------------------------
   rg_pin_channel u_chan_a (
      .clk_sys(clk_sys), .rst_b(rst_b), .pin_in(req_grant_a_in),
      .pin_out(req_grant_a_out), .pin_oe_b(req_grant_a_oe_b), .link(link_a));
   rg_pin_channel u_chan_b (
      .clk_sys(clk_sys), .rst_b(rst_b), .pin_in(req_grant_b_in),
      .pin_out(req_grant_b_out), .pin_oe_b(req_grant_b_oe_b), .link(link_b));
   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   // Strap synchronised then read; ground means max mode
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         strap_s1 <= 1'h1;
         strap_s2 <= 1'h1;
         max_mode <= 1'h0;
      end
      else
      begin
         strap_s1 <= mode_strap;
         strap_s2 <= strap_s1;
         // RULE_16 strap grounded only
         max_mode <= ~strap_s2;
      end
   end
   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   wire a_req = link_a.pulse_seen;
   wire b_req = link_b.pulse_seen;
   wire in_mem_cycle = (cycle_phase != CYC_NONE);
   wire grant_slot = (cycle_phase == CYC_FINAL) || (cycle_phase == CYC_ADDR) || !in_mem_cycle;
   wire locked_now = lock_prefix_hold || lock_ack_hold;
   // RULE_07 release conditions
   wire release_ok = !late && !ack_in_cycle && !locked_now;
   wire owner_release = (owner == 2'h1) ? a_req : b_req;
   // RULE_02 request pulse seen
   wire new_req = a_req || b_req;
   // ----------------------------------------
   // Handover sequencing
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         HO_OWN:
            if (req_taken && grant_slot && release_ok)
               // RULE_03 grant in final/addr
               next_state = HO_GRANT;
         HO_GRANT:
            next_state = HO_HELD;
         HO_HELD:
            // RULE_04 third pulse ends hold
            if (owner_release)
               next_state = HO_RECLAIM;
         HO_RECLAIM:
            // RULE_06 idle clock after exchange
            next_state = HO_IDLE;
         HO_IDLE:
            next_state = HO_OWN;
         default:
            next_state = HO_OWN;
      endcase
   end
   // RULE_08 idle bus granted quickly
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !max_mode)
      begin
         state <= HO_OWN;
         req_taken <= 1'h0;
         owner <= 2'h0;
         late <= 1'h0;
      end
      else
      begin
         state <= next_state;
         if (state == HO_OWN && !req_taken && new_req && owner == 2'h0)
         begin
            req_taken <= 1'h1;
            // RULE_01 channel A first
            owner <= a_req ? 2'h1 : 2'h2;
            // RULE_07 early request check
            // RULE_09 idle counts as early
            late <= (cycle_phase == CYC_THIRD) || (cycle_phase == CYC_FINAL);
         end
         // RULE_09 cycle started in idle window counts as early
         else if (state == HO_OWN && (cycle_phase == CYC_ADDR || idle_cnt != 2'h0))
            late <= 1'h0;
         if (next_state == HO_GRANT)
            req_taken <= 1'h0;
         if (state == HO_IDLE)
            owner <= 2'h0;
      end
   end
   // Grant pulse drive and bus outputs
   assign drive_a = (next_state == HO_GRANT) && (owner == 2'h1);
   assign drive_b = (next_state == HO_GRANT) && (owner == 2'h2);
   assign link_a.drive_pulse = drive_a;
   assign link_b.drive_pulse = drive_b;
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         bus_float <= 1'h0;
         bus_owned <= 1'h1;
         idle_cnt <= 2'h0;
         ack_in_cycle <= 1'h0;
      end
      else
      begin
         // RULE_03 float next clock
         // RULE_18 disconnected while held
         bus_float <= (next_state == HO_HELD);
         // RULE_05 reclaim next clock
         bus_owned <= (next_state != HO_HELD) && (next_state != HO_GRANT);
         // RULE_09 idle start window
         idle_cnt <= (req_taken && !in_mem_cycle && idle_cnt < 2'(`IDLE_START_CYC)) ?
            idle_cnt + 2'h1 : 2'h0;
         ack_in_cycle <= int_ack_first;
      end
   end
   // ----------------------------------------
   // Bus lock
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         lock_prefix_hold <= 1'h0;
         lock_ack_hold <= 1'h0;
         bus_lock_b <= `LOCK_RST;
         bus_lock_oe_b <= 1'h0;
      end
      else
      begin
         // RULE_10 lock until next done
         if (lock_prefix)
            lock_prefix_hold <= 1'h1;
         else if (instr_done)
            lock_prefix_hold <= 1'h0;
         // RULE_11 ack pair lock
         if (int_ack_first && max_mode)
            lock_ack_hold <= 1'h1;
         else if (int_ack_second && cycle_phase == CYC_SECOND)
            lock_ack_hold <= 1'h0;
         bus_lock_b <= ~(lock_prefix || lock_prefix_hold ||
            (max_mode && int_ack_first) || lock_ack_hold);
         bus_lock_oe_b <= (next_state == HO_HELD);
      end
   end
   // ----------------------------------------
   // Queue status and byte-high enable
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         queue_state_hi <= 1'h0;
         queue_state_lo <= 1'h0;
         byte_hi_en <= 1'h1;
         byte_hi_oe_b <= 1'h0;
      end
      else
      begin
         // RULE_12 code one clock later
         // RULE_13 always driven
         // RULE_14 code bit order
         queue_state_hi <= max_mode & queue_op[1];
         queue_state_lo <= max_mode & queue_op[0];
         // RULE_15 constant one, float held
         byte_hi_en <= 1'h1;
         byte_hi_oe_b <= (next_state == HO_HELD) || (next_state == HO_GRANT);
      end
   end
endmodule // max_mode_bus_handover

// ---- tb/max_mode_bus_handover_chk.sv ----
// Port checks of the bus handover logic
`timescale 1ns/10ps
module max_mode_bus_handover_chk
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic mode_strap,
   input wire logic lock_prefix,
   input wire logic [1:0] queue_op,
   input wire logic req_grant_a_oe_b,
   input wire logic req_grant_b_oe_b,
   input wire logic bus_float,
   input wire logic bus_owned,
   input wire logic bus_lock_b,
   input wire logic bus_lock_oe_b,
   input wire logic queue_state_hi,
   input wire logic queue_state_lo,
   input wire logic byte_hi_en,
   input wire logic byte_hi_oe_b
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   grant_width_a: assert property ($fell(req_grant_a_oe_b) |=> req_grant_a_oe_b)
      else $error("grant too long");
   grant_float_a: assert property (
      !(req_grant_a_oe_b && req_grant_b_oe_b) |=> bus_float) else $error("no float");
   float_owned_a: assert property (bus_float |-> !bus_owned) else $error("owned in float");
   pin_float_a: assert property (
      bus_float && $past(bus_float) |-> byte_hi_oe_b && bus_lock_oe_b && byte_hi_en)
      else $error("pins not floated high");
   lock_set_a: assert property (lock_prefix && !bus_float |=> !bus_lock_b)
      else $error("lock not set");
   locked_refuse_a: assert property (
      !bus_lock_b && $past(!bus_lock_b) |-> req_grant_a_oe_b && req_grant_b_oe_b)
      else $error("grant while locked");
   queue_follow_a: assert property (
      (!mode_strap) [*5] |=> {queue_state_hi, queue_state_lo} == $past(queue_op))
      else $error("queue code wrong");
   queue_strap_a: assert property (
      mode_strap [*5] |-> {queue_state_hi, queue_state_lo} == 2'h0)
      else $error("queue code in min mode");
endmodule // max_mode_bus_handover_chk
bind max_mode_bus_handover max_mode_bus_handover_chk i_chk (.*);

// ---- tb/rg_master_model.sv ----
// Requesting bus master on one request/grant line
`timescale 1ns/10ps
module rg_master_model
(
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [3:0] hold_len,
   input wire logic line,
   output logic pull_low,
   output logic got_grant
);
   int i;
   // One exchange per go: request, wait for grant, hold, release
   initial
   begin
      pull_low = 1'b0;
      got_grant = 1'b0;
      forever
      begin
         @(posedge clk_sys);
         if (go)
         begin
            got_grant <= 1'b0;
            pull_low <= 1'b1;
            @(posedge clk_sys);
            pull_low <= 1'b0;
            @(posedge clk_sys);
            for (i = 0; i < 60 && line !== 1'b0; i++)
               @(posedge clk_sys);
            if (i < 60)
            begin
               got_grant <= 1'b1;
               repeat (hold_len) @(posedge clk_sys);
               pull_low <= 1'b1;
               @(posedge clk_sys);
               pull_low <= 1'b0;
               got_grant <= 1'b0;
            end
         end
      end
   end
endmodule // rg_master_model

// ---- tb/max_mode_bus_handover_tb.sv ----
// Bench for the bus handover logic with two requesting masters
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %h, expected %h", $time, g, e); end end
module max_mode_bus_handover_tb;
   import bus_handover_pkg::*;
   logic clk_sys = 1'b0, rst_b = 1'b0, mode_strap = 1'b0, cycle_pending = 1'b0;
   logic int_ack_first = 1'b0, int_ack_second = 1'b0, lock_prefix = 1'b0, instr_done = 1'b0;
   logic cycling = 1'b0, go_a = 1'b0, go_b = 1'b0, pull_a, pull_b, got_a, got_b;
   logic [1:0] queue_op = 2'h0, qs_exp;
   logic [1:0] exp_q[$];
   logic [3:0] hold_len = 4'h1;
   cycle_phase_t cycle_phase;
   logic req_grant_a_in, req_grant_a_out, req_grant_a_oe_b, req_grant_b_in, req_grant_b_out;
   logic req_grant_b_oe_b, bus_float, bus_owned, bus_lock_b, bus_lock_oe_b;
   logic queue_state_hi, queue_state_lo, byte_hi_en, byte_hi_oe_b;
   int n_errors = 0, comparisons = 0;
   max_mode_bus_handover i_dut (.*);
   rg_master_model i_ma (.clk_sys, .go(go_a), .hold_len, .line(req_grant_a_in),
      .pull_low(pull_a), .got_grant(got_a));
   rg_master_model i_mb (.clk_sys, .go(go_b), .hold_len, .line(req_grant_b_in),
      .pull_low(pull_b), .got_grant(got_b));
   // Clock and pulled-up open-drain lines
   always #5 clk_sys = ~clk_sys;
   assign req_grant_a_in = (req_grant_a_oe_b | req_grant_a_out) & ~pull_a;
   assign req_grant_b_in = (req_grant_b_oe_b | req_grant_b_out) & ~pull_b;
   // Core bus phases, only while the bus is owned
   always @(posedge clk_sys)
      cycle_phase <= !(cycling && bus_owned) ? CYC_NONE
         : cycle_phase == CYC_FINAL ? CYC_ADDR : cycle_phase_t'(cycle_phase + 3'h1);
   // Queue code monitor
   always @(negedge clk_sys)
      if (exp_q.size() > 0)
      begin
         qs_exp = exp_q.pop_front();
         `CHK({queue_state_hi, queue_state_lo}, qs_exp)
      end
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic run_queue(int n, logic [1:0] mask);
      logic [1:0] v;
      for (int i = 0; i < n; i++)
      begin
         v = (i < 4) ? 2'(i) : 2'($urandom);
         queue_op <= v;
         tick(1);
         exp_q.push_back(v & mask);
      end
      queue_op <= 2'h0;
   endtask
   task automatic exchange(logic a, logic b, logic ea, logic eb, logic [3:0] hold);
      int i;
      go_a <= a;
      go_b <= b;
      hold_len <= hold;
      tick(1);
      go_a <= 1'b0;
      go_b <= 1'b0;
      tick(1);
      for (i = 0; i < 60 && !(got_a || got_b); i++)
         tick(1);
      if (i == 60 && (ea || eb))
      begin
         n_errors++;
         $display("Error at %0t: no grant seen", $time);
         end_of_test();
      end
      `CHK({got_a, got_b}, {ea, eb})
      @(negedge clk_sys);
      `CHK({bus_float, bus_owned}, {ea | eb, !(ea | eb)})
      tick(60);
      `CHK({bus_float, bus_owned}, 2'b01)
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      void'($urandom(85));
      tick(20);
      rst_b <= 1'b1;
      tick(4);
      `CHK({req_grant_a_oe_b, req_grant_b_oe_b, bus_lock_b, byte_hi_en}, 4'hF)
      run_queue(24, 2'h3);
      exchange(1'b1, 1'b0, 1'b1, 1'b0, 4'h1);
      exchange(1'b0, 1'b1, 1'b0, 1'b1, 4'h9);
      exchange(1'b1, 1'b1, 1'b1, 1'b0, 4'h2);
      lock_prefix <= 1'b1;
      tick(1);
      lock_prefix <= 1'b0;
      // Request while locked is held off, granted once the lock ends
      go_a <= 1'b1;
      hold_len <= 4'h2;
      tick(1);
      go_a <= 1'b0;
      tick(20);
      `CHK({got_a, bus_float, bus_owned, bus_lock_b}, 4'h2)
      `CHK(bus_lock_b, 1'b0)
      instr_done <= 1'b1;
      tick(1);
      instr_done <= 1'b0;
      tick(2);
      `CHK(bus_lock_b, 1'b1)
      for (int i = 0; i < 30 && !got_a; i++)
         tick(1);
      `CHK(got_a, 1'b1)
      tick(30);
      `CHK({bus_float, bus_owned}, 2'b01)
      cycling <= 1'b1;
      fork
         exchange(1'b1, 1'b0, 1'b1, 1'b0, 4'($urandom_range(1, 9)));
         run_queue(40, 2'h3);
      join
      int_ack_first <= 1'b1;
      tick(4);
      int_ack_first <= 1'b0;
      int_ack_second <= 1'b1;
      `CHK(bus_lock_b, 1'b0)
      tick(4);
      int_ack_second <= 1'b0;
      tick(3);
      `CHK(bus_lock_b, 1'b1)
      mode_strap <= 1'b1;
      tick(6);
      run_queue(8, 2'h0);
      tick(2);
      end_of_test();
   end
endmodule // max_mode_bus_handover_tb
